// file: include/serial_port_pkg.sv
// shared constants and types for the serial port
package serial_port_pkg;
  // register indices
  localparam logic [1:0] CTRL_ADDR = 2'h0;
  localparam logic [1:0] DATA_ADDR = 2'h1;
  localparam logic [1:0] RELOAD_ADDR = 2'h2;
  localparam logic [1:0] TIMER_ADDR = 2'h3;
  // serial_control_reg fields
  localparam int MODE_BIT = 7;
  localparam int UNUSED_BIT = 6;
  localparam int QUAL_BIT = 5;
  localparam int REN_BIT = 4;
  localparam int TB8_BIT = 3;
  localparam int RB8_BIT = 2;
  localparam int TI_BIT = 1;
  localparam int RI_BIT = 0;
  // timer control fields
  localparam int RUN_BIT = 0;
  localparam int IRQ_EN_BIT = 1;
  // reset values
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // baud channels
  localparam int TX_CH = 0;
  localparam int RX_CH = 1;
  localparam int NUM_CH = 2;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_NINTH = 3'b011,
    TX_STOP = 3'b100
  } tx_state_e;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_NINTH = 3'b011,
    RX_STOP = 3'b100
  } rx_state_e;
endpackage

// file: logic/baud_counter.sv
// 8-bit auto-reload counter with divide-by-two bit tick
`timescale 1ns/1ns
`default_nettype none
module baud_counter import serial_port_pkg::*; #(
  parameter int WIDTH = 8
) (
  // clocking
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // control
  input wire logic count_en,
  input wire logic force_reload,
  input wire logic [WIDTH-1:0] reload,
  // result
  output logic bit_tick
);
  logic [WIDTH-1:0] cnt_reg;
  logic phase_reg;
  logic ovf;

  if (WIDTH < 2) begin : g_chk
    $error("baud_counter: WIDTH too small");
  end

  assign ovf = count_en && (cnt_reg == {WIDTH{1'b1}});
  // first overflow after a forced reload lands mid-bit
  assign bit_tick = ovf && !phase_reg && !force_reload;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cnt_reg <= '0;
    end else if (clk_en) begin
      if (force_reload || ovf) begin
        cnt_reg <= reload;
      end else if (count_en) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      phase_reg <= 1'b0;
    end else if (clk_en) begin
      if (force_reload) begin
        phase_reg <= 1'b0;
      end else if (ovf) begin
        phase_reg <= !phase_reg;
      end
    end
  end

  a_forced_reload: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && force_reload |=> cnt_reg == $past(reload))
    else $error("counter did not reload on force");

  a_overflow_halved: assert property (@(posedge sys_clk) disable iff (reset)
    bit_tick |=> !bit_tick ##0 phase_reg)
    else $error("bit tick not divided by two");
endmodule
`default_nettype wire

// file: logic/serial_port.sv
// full-duplex serial port with baud timer and data buffer
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module serial_port import serial_port_pkg::*; #(
  parameter int DATA_BITS = 8
) (
  // clocking
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // timer input clock, one pulse per timer count
  input wire logic timer_tick,
  // register port
  input wire bus_req_s bus_req,
  output logic [7:0] rdata,
  // serial pins
  input wire logic serial_rx_pin,
  output logic serial_tx_pin,
  // interrupt
  output logic irq
);
  localparam int CW = $clog2(DATA_BITS);

  if (DATA_BITS < 2 || DATA_BITS > 8) begin : g_chk
    $error("serial_port: DATA_BITS must be 2..8");
  end

  // registers
  logic frame_length_select;
  logic rx_qualifier_enable;
  logic rx_enable_bit;
  logic tx_ninth_bit;
  logic rx_ninth_bit;
  logic tx_done_flag;
  logic rx_done_flag;
  logic [7:0] baud_timer_reload_byte;
  logic timer_run_reg;
  logic irq_en_reg;
  logic [7:0] rx_buffer_reg;
  logic [7:0] tx_hold_reg;
  logic tx_pend_reg;

  logic ctrl_wr;
  logic data_wr;
  assign ctrl_wr = clk_en && bus_req.wr && bus_req.addr == CTRL_ADDR;
  assign data_wr = clk_en && bus_req.wr && bus_req.addr == DATA_ADDR;

  // transmit state
  tx_state_e tx_state_reg;
  logic [7:0] tx_shift_reg;
  logic [CW-1:0] tx_cnt_reg;
  logic tx_done_set;

  // receive state
  rx_state_e rx_state_reg;
  logic [7:0] rx_shift_reg;
  logic [CW-1:0] rx_cnt_reg;
  logic rx_ninth_cap_reg;
  logic rx_done_set;
  logic rx_accept;
  logic [2:0] rx_sync_reg;
  logic rx_level_reg;
  logic rx_prev_reg;
  logic rx_start_det;

  // baud channels
  logic [NUM_CH-1:0] ch_force;
  logic [NUM_CH-1:0] ch_tick;

  assign ch_force[TX_CH] = 1'b0;
  assign ch_force[RX_CH] = rx_start_det;

  // both counters run only while the timer runs, one shared reload byte
  for (genvar i = 0; i < NUM_CH; i++) begin : g_baud
    baud_counter #(.WIDTH(8)) u_baud (
      .sys_clk(sys_clk),
      .reset(reset),
      .clk_en(clk_en),
      .count_en(timer_run_reg && timer_tick),
      .force_reload(ch_force[i]),
      .reload(baud_timer_reload_byte),
      .bit_tick(ch_tick[i])
    );
  end

  // control register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      frame_length_select <= 1'b0;
      rx_qualifier_enable <= 1'b0;
      rx_enable_bit <= 1'b0;
      tx_ninth_bit <= 1'b0;
    end else if (ctrl_wr) begin
      frame_length_select <= bus_req.wdata[MODE_BIT];
      rx_qualifier_enable <= bus_req.wdata[QUAL_BIT];
      rx_enable_bit <= bus_req.wdata[REN_BIT];
      tx_ninth_bit <= bus_req.wdata[TB8_BIT];
    end
  end

  // set beats clear so a same-cycle event is never lost
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_done_flag <= 1'b0;
      rx_done_flag <= 1'b0;
    end else if (clk_en) begin
      if (tx_done_set) begin
        tx_done_flag <= 1'b1;
      end else if (ctrl_wr) begin
        tx_done_flag <= bus_req.wdata[TI_BIT];
      end
      if (rx_done_set) begin
        rx_done_flag <= 1'b1;
      end else if (ctrl_wr) begin
        rx_done_flag <= bus_req.wdata[RI_BIT];
      end
    end
  end

  // ninth-bit field: hardware load wins over software write
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rx_ninth_bit <= 1'b0;
    end else if (clk_en) begin
      if (rx_accept) begin
        // 8-bit stop level is sampled at this very tick; the capture lags one cycle
        rx_ninth_bit <= frame_length_select ? rx_ninth_cap_reg : rx_level_reg;
      end else if (ctrl_wr) begin
        rx_ninth_bit <= bus_req.wdata[RB8_BIT];
      end
    end
  end

  // timer reload and timer control
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      baud_timer_reload_byte <= RELOAD_RESET;
      timer_run_reg <= 1'b0;
      irq_en_reg <= 1'b0;
    end else if (clk_en && bus_req.wr) begin
      if (bus_req.addr == RELOAD_ADDR) begin
        baud_timer_reload_byte <= bus_req.wdata;
      end
      if (bus_req.addr == TIMER_ADDR) begin
        timer_run_reg <= bus_req.wdata[RUN_BIT];
        irq_en_reg <= bus_req.wdata[IRQ_EN_BIT];
      end
    end
  end

  // read data, one cycle after the strobe; transmitter never readable
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata <= BYTE_ZERO;
    end else if (clk_en) begin
      if (bus_req.rd) begin
        unique case (bus_req.addr)
          CTRL_ADDR: rdata <= {frame_length_select, 1'b1, rx_qualifier_enable, rx_enable_bit,
                               tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag};
          DATA_ADDR: rdata <= rx_buffer_reg;
          RELOAD_ADDR: rdata <= baud_timer_reload_byte;
          TIMER_ADDR: rdata <= {6'h00, irq_en_reg, timer_run_reg};
        endcase
      end else begin
        rdata <= BYTE_ZERO;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= irq_en_reg && (tx_done_flag || rx_done_flag);
    end
  end

  // transmit holding register; a write while busy queues the next byte
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_hold_reg <= BYTE_ZERO;
      tx_pend_reg <= 1'b0;
    end else if (clk_en) begin
      if (data_wr) begin
        tx_hold_reg <= bus_req.wdata;
        tx_pend_reg <= 1'b1;
      end else if (ch_tick[TX_CH] && tx_state_reg == TX_IDLE) begin
        tx_pend_reg <= 1'b0;
      end
    end
  end

  assign tx_done_set = ch_tick[TX_CH] && (tx_state_reg == TX_NINTH ||
    (tx_state_reg == TX_DATA && tx_cnt_reg == CW'(DATA_BITS - 1) && !frame_length_select));

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_state_reg <= TX_IDLE;
      tx_shift_reg <= BYTE_ZERO;
      tx_cnt_reg <= '0;
      serial_tx_pin <= 1'b1;
    end else if (clk_en && ch_tick[TX_CH]) begin
      unique case (tx_state_reg)
        TX_IDLE: begin
          if (tx_pend_reg) begin
            tx_shift_reg <= tx_hold_reg;
            tx_cnt_reg <= '0;
            serial_tx_pin <= 1'b0;
            tx_state_reg <= TX_START;
          end
        end
        TX_START: begin
          serial_tx_pin <= tx_shift_reg[0];
          tx_shift_reg <= tx_shift_reg >> 1;
          tx_state_reg <= TX_DATA;
        end
        TX_DATA: begin
          if (tx_cnt_reg == CW'(DATA_BITS - 1)) begin
            if (frame_length_select) begin
              serial_tx_pin <= tx_ninth_bit;
              tx_state_reg <= TX_NINTH;
            end else begin
              serial_tx_pin <= 1'b1;
              tx_state_reg <= TX_STOP;
            end
          end else begin
            serial_tx_pin <= tx_shift_reg[0];
            tx_shift_reg <= tx_shift_reg >> 1;
            tx_cnt_reg <= tx_cnt_reg + 1'b1;
          end
        end
        TX_NINTH: begin
          serial_tx_pin <= 1'b1;
          tx_state_reg <= TX_STOP;
        end
        TX_STOP: begin
          tx_state_reg <= TX_IDLE;
        end
        default: begin
          serial_tx_pin <= 1'b1;
          tx_state_reg <= TX_IDLE;
        end
      endcase
    end
  end

  // receive pin: three-stage filter; level moves only when stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rx_sync_reg <= 3'h7;
      rx_level_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else if (clk_en) begin
      rx_sync_reg <= {rx_sync_reg[1:0], serial_rx_pin};
      if (rx_sync_reg[1] == rx_sync_reg[2]) begin
        rx_level_reg <= rx_sync_reg[2];
      end
      rx_prev_reg <= rx_level_reg;
    end
  end

  assign rx_start_det = clk_en && rx_enable_bit && rx_state_reg == RX_IDLE &&
                        rx_prev_reg && !rx_level_reg;

  assign rx_done_set = rx_accept;
  // overrun leaves the buffer with the earlier byte
  assign rx_accept = ch_tick[RX_CH] && rx_state_reg == RX_STOP && !rx_done_flag &&
    (!rx_qualifier_enable || (frame_length_select ? rx_ninth_cap_reg : rx_level_reg));

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rx_buffer_reg <= BYTE_ZERO;
    end else if (clk_en && rx_accept) begin
      rx_buffer_reg <= rx_shift_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rx_state_reg <= RX_IDLE;
      rx_shift_reg <= BYTE_ZERO;
      rx_cnt_reg <= '0;
      rx_ninth_cap_reg <= 1'b0;
    end else if (clk_en) begin
      if (rx_start_det) begin
        rx_state_reg <= RX_START;
      end else if (ch_tick[RX_CH]) begin
        unique case (rx_state_reg)
          RX_IDLE: begin
          end
          RX_START: begin
            rx_cnt_reg <= '0;
            // a glitch shorter than half a bit is not a start
            rx_state_reg <= rx_level_reg ? RX_IDLE : RX_DATA;
          end
          RX_DATA: begin
            rx_shift_reg <= {rx_level_reg, rx_shift_reg[7:1]};
            rx_cnt_reg <= rx_cnt_reg + 1'b1;
            if (rx_cnt_reg == CW'(DATA_BITS - 1)) begin
              rx_state_reg <= frame_length_select ? RX_NINTH : RX_STOP;
            end
          end
          RX_NINTH: begin
            rx_ninth_cap_reg <= rx_level_reg;
            rx_state_reg <= RX_STOP;
          end
          RX_STOP: begin
            // in 8-bit framing the stop level is the ninth-bit field
            if (!frame_length_select) begin
              rx_ninth_cap_reg <= rx_level_reg;
            end
            rx_state_reg <= RX_IDLE;
          end
          default: begin
            rx_state_reg <= RX_IDLE;
          end
        endcase
      end
    end
  end

  a_tx_done_stop: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(tx_done_flag) |-> tx_state_reg == TX_STOP && serial_tx_pin)
    else $error("transmit done not at stop bit");

  a_start_bit_low: assert property (@(posedge sys_clk) disable iff (reset)
    tx_state_reg == TX_START |-> !serial_tx_pin)
    else $error("start bit not low");

  a_ninth_bit_out: assert property (@(posedge sys_clk) disable iff (reset)
    tx_state_reg == TX_NINTH && $stable(tx_ninth_bit) |-> serial_tx_pin == tx_ninth_bit)
    else $error("ninth bit wrong on line");

  a_flag_sticky: assert property (@(posedge sys_clk) disable iff (reset)
    rx_done_flag && !ctrl_wr |=> rx_done_flag)
    else $error("receive flag cleared by hardware");

  a_rx_accept_gate: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(rx_done_flag) |-> $past(rx_state_reg) == RX_STOP && $past(rx_state_reg) != RX_IDLE
      && (!rx_qualifier_enable || rx_ninth_bit))
    else $error("frame accepted without qualifier");

  a_rx_disabled: assert property (@(posedge sys_clk) disable iff (reset)
    !rx_enable_bit && rx_state_reg == RX_IDLE |=> rx_state_reg == RX_IDLE)
    else $error("reception while disabled");

  a_buffer_keeps: assert property (@(posedge sys_clk) disable iff (reset)
    rx_done_flag && !ctrl_wr |=> $stable(rx_buffer_reg))
    else $error("buffer overwritten on overrun");

  a_read_buffer: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && bus_req.rd && bus_req.addr == DATA_ADDR |=> rdata == $past(rx_buffer_reg))
    else $error("data read not from receive buffer");

  a_irq_follows: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && irq_en_reg && $rose(tx_done_flag) |=> irq)
    else $error("interrupt not raised");
endmodule
`default_nettype wire

// file: tb/serial_remote.sv
// remote serial device model: sends frames to the port and captures its output
`timescale 1ns/1ns
`default_nettype none
module serial_remote #(
  parameter int BIT_CYC = 32
) (
  // clocking
  input wire logic sys_clk,
  // link
  input wire logic nine_mode,
  input wire logic line_in,
  output logic line_out
);
  logic [7:0] got_data;
  logic got_ninth;
  logic got_stop;
  int got_cnt;
  int i;

  initial begin
    line_out = 1'h1;
    got_data = 8'h00;
    got_ninth = 1'h0;
    got_stop = 1'h0;
    got_cnt = 0;
  end

  // one frame, least significant bit first, then one idle bit
  task automatic send_frame(input logic [7:0] d, input logic nine, input logic ninth, input logic stop);
    int k;
    @(posedge sys_clk);
    line_out <= 1'h0;
    repeat (BIT_CYC) @(posedge sys_clk);
    for (k = 0; k < 8; k++) begin
      line_out <= d[k];
      repeat (BIT_CYC) @(posedge sys_clk);
    end
    if (nine) begin
      line_out <= ninth;
      repeat (BIT_CYC) @(posedge sys_clk);
    end
    line_out <= stop;
    repeat (BIT_CYC) @(posedge sys_clk);
    line_out <= 1'h1;
    repeat (BIT_CYC) @(posedge sys_clk);
  endtask

  // capture sampled at bit centres; a broken frame length shows as a wrong ninth or stop bit
  always begin
    @(negedge line_in);
    repeat (BIT_CYC / 2) @(posedge sys_clk);
    for (i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge sys_clk);
      got_data[i] = line_in;
    end
    if (nine_mode) begin
      repeat (BIT_CYC) @(posedge sys_clk);
      got_ninth = line_in;
    end
    repeat (BIT_CYC) @(posedge sys_clk);
    got_stop = line_in;
    got_cnt++;
  end
endmodule
`default_nettype wire

// file: tb/serial_port_bench.sv
// self-checking bench for the serial port
`timescale 1ns/1ns
`default_nettype none
module serial_port_bench import serial_port_pkg::*;;
  localparam logic [7:0] RELOAD = 8'hF0;
  localparam int BIT_CYC = 2 * (256 - 240);
  localparam int LIMIT = 20000;
  // receive cases, one bit or entry per case
  localparam logic [6:0] C_MODE = 7'h70;
  localparam logic [6:0] C_QUAL = 7'h34;
  localparam logic [6:0] C_REN = 7'h3F;
  localparam logic [6:0] C_KEEP = 7'h02;
  localparam logic [6:0] C_NINTH = 7'h60;
  localparam logic [6:0] C_STOP = 7'h73;
  logic [7:0] c_data [7] = '{8'h3C, 8'hC3, 8'h55, 8'h55, 8'h66, 8'h99, 8'h77};
  logic [7:0] c_exp [7] = '{8'h3C, 8'h3C, 8'h3C, 8'h55, 8'h55, 8'h99, 8'h99};
  logic [7:0] c_flag [7] = '{8'h05, 8'h05, 8'h00, 8'h01, 8'h00, 8'h05, 8'h00};

  logic sys_clk = 1'h0;
  logic reset = 1'h1;
  logic clk_en = 1'h1;
  logic timer_tick = 1'h1;
  bus_req_s bus_req = '0;
  logic [7:0] rdata;
  logic serial_rx_pin;
  logic serial_tx_pin;
  logic irq;
  logic nine_rx = 1'h0;
  logic slow_tick = 1'h0;
  logic prev_tx = 1'h1;
  logic [7:0] v;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int last_rise = 0;
  int n;
  int k;

  serial_port #(.DATA_BITS(8)) DUT (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
    .timer_tick(timer_tick), .bus_req(bus_req), .rdata(rdata), .serial_rx_pin(serial_rx_pin),
    .serial_tx_pin(serial_tx_pin), .irq(irq));
  serial_remote #(.BIT_CYC(BIT_CYC)) remote (.sys_clk(sys_clk), .nine_mode(nine_rx),
    .line_in(serial_tx_pin), .line_out(serial_rx_pin));

  always #5 sys_clk = ~sys_clk;

  // cycle stamp of the latest rising edge on the transmit pin
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    prev_tx <= serial_tx_pin;
    if (slow_tick) begin
      timer_tick <= !timer_tick;
    end
    if (serial_tx_pin === 1'h1 && prev_tx === 1'h0) begin
      last_rise <= cyc;
    end
    if (cyc == LIMIT) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge sys_clk);
    bus_req <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
    @(posedge sys_clk);
    bus_req <= '0;
    #1 d = rdata;
  endtask

  // writing control also clears both done flags
  task automatic set_ctrl(input logic mode, input logic qual, input logic ren, input logic tb8);
    reg_wr(CTRL_ADDR, {mode, 1'h0, qual, ren, tb8, 3'h0});
  endtask

  task automatic wait_sig(input logic use_irq, input logic lvl, output int cnt);
    cnt = 0;
    do begin
      @(posedge sys_clk);
      #1 cnt++;
    // first tick after the timer starts comes only after a full count from zero
    end while ((use_irq ? irq : serial_tx_pin) !== lvl && cnt < 12 * BIT_CYC);
  endtask

  task automatic wait_frames(input int total);
    int w;
    w = 0;
    while (remote.got_cnt < total && w < 20 * BIT_CYC) begin
      @(posedge sys_clk);
      w++;
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'h0;
    reg_rd(CTRL_ADDR, v);
    check(v, 8'h40);
    reg_rd(RELOAD_ADDR, v);
    check(v, RELOAD_RESET);
    check({7'h00, serial_tx_pin}, 8'h01);
    $display("test reset values done");
    // overflows at twice the bit rate
    reg_wr(RELOAD_ADDR, RELOAD);
    reg_wr(TIMER_ADDR, 8'h03);
    reg_wr(DATA_ADDR, 8'h35);
    wait_sig(1'h0, 1'h0, n);
    check({7'h00, serial_tx_pin}, 8'h00);
    wait_sig(1'h0, 1'h1, n);
    check(n[7:0], BIT_CYC[7:0]);
    // stop bit follows a low data bit here, so its rising edge marks it
    wait_sig(1'h1, 1'h1, n);
    check({7'h00, cyc - last_rise <= 2}, 8'h01);
    wait_frames(1);
    check(remote.got_data, 8'h35);
    check({7'h00, remote.got_stop}, 8'h01);
    reg_rd(CTRL_ADDR, v);
    check(v, 8'h42);
    repeat (60) @(posedge sys_clk);
    #1 check({7'h00, irq}, 8'h01);
    set_ctrl(1'h0, 1'h0, 1'h0, 1'h0);
    repeat (3) @(posedge sys_clk);
    #1 check({7'h00, irq}, 8'h00);
    $display("test 8-bit transmit done");
    nine_rx <= 1'h1;
    for (k = 0; k < 2; k++) begin
      reg_wr(TIMER_ADDR, {6'h00, k[0], 1'h1});
      set_ctrl(1'h1, 1'h0, 1'h0, k[0]);
      reg_wr(DATA_ADDR, 8'hC6 ^ k[7:0]);
      wait_frames(2 + k);
      check(remote.got_data, 8'hC6 ^ k[7:0]);
      check({7'h00, remote.got_ninth}, {7'h00, k[0]});
      check({7'h00, remote.got_stop}, 8'h01);
      check({7'h00, irq}, {7'h00, k[0]});
    end
    $display("test 9-bit transmit done");
    for (k = 0; k < 7; k++) begin
      if (!C_KEEP[k]) begin
        set_ctrl(C_MODE[k], C_QUAL[k], C_REN[k], 1'h0);
      end
      // frames start at no fixed phase of the transmit counter
      remote.send_frame(c_data[k], C_MODE[k], C_NINTH[k], C_STOP[k]);
      reg_rd(DATA_ADDR, v);
      check(v, c_exp[k]);
      reg_rd(CTRL_ADDR, v);
      check(v & 8'h05, c_flag[k]);
      check({7'h00, irq}, {7'h00, c_flag[k][0]});
    end
    $display("test receive cases done");
    // half-rate timer input doubles the bit time
    slow_tick <= 1'h1;
    reg_wr(DATA_ADDR, 8'hA5);
    wait_sig(1'h0, 1'h0, n);
    wait_sig(1'h0, 1'h1, n);
    check(n[7:0], 8'(2 * BIT_CYC));
    $display("test timer input rate done");
    // receive counter stands still while the timer is stopped
    reg_wr(TIMER_ADDR, 8'h00);
    set_ctrl(1'h0, 1'h0, 1'h1, 1'h0);
    remote.send_frame(8'hA5, 1'h0, 1'h0, 1'h1);
    reg_rd(DATA_ADDR, v);
    check(v, 8'h99);
    reg_rd(CTRL_ADDR, v);
    check(v & 8'h05, 8'h00);
    $display("test stopped timer done");
    print_verdict();
  end
endmodule
`default_nettype wire
